// File: core/fwd_cfg_pkg.sv
package fwd_cfg_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_STP = 16'h1843;
    localparam logic [15:0] IDX_PQM = 16'h1845;
    localparam logic [15:0] IDX_MIR = 16'h1846;
    localparam logic [15:0] IDX_ITS = 16'h1847;
    localparam logic [15:0] IDX_BCL = 16'h1848;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h1850;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h1851;

    // Implemented widths of each register; bits above read as zero.
    localparam int W_STP = 6;
    localparam int W_PQM = 16;
    localparam int W_MIR = 9;
    localparam int W_ITS = 6;
    localparam int W_BCL = 27;

    // Values after reset.
    localparam logic [W_STP-1:0] RST_STP = 6'h00;
    localparam logic [W_PQM-1:0] RST_PQM = 16'hFA41;
    localparam logic [W_MIR-1:0] RST_MIR = 9'h000;
    localparam logic [W_ITS-1:0] RST_ITS = 6'h00;
    localparam logic [W_BCL-1:0] RST_BCL = 27'h0080402;

    // Mirroring control field positions.
    localparam int MIR_TX_BIT = 0;
    localparam int MIR_RX_BIT = 1;
    localparam int MIR_MAP_LSB = 2;
    localparam int MIR_SNIF_LSB = 5;
    localparam int MIR_FILT_BIT = 8;

    // Broadcast limit layout: one 9-bit group per port, level low, enable on top.
    localparam int BCL_STRIDE = 9;
    localparam int BCL_EN_OFS = 8;
    localparam int BCL_LVL_W = 8;
    localparam int BCL_UNIT_SHIFT = 6;

    // Ingress type value that takes the destination from the VLAN tag.
    localparam logic [1:0] ITS_VLAN_DEST = 2'h3;

    // Interrupt event bits.
    localparam int EV_FILT = 0;
    localparam int EV_THR = 1;
    localparam int EV_STP = 2;
    localparam int EV_W = 3;

    // Throttle interval and the clock it is counted on.
    localparam real THROTTLE_INTERVAL_MS = 1.72;
    localparam real CLK_MHZ = 125.0;
    localparam int INTERVAL_CYCLES = int'(THROTTLE_INTERVAL_MS * 1000.0 * CLK_MHZ);

    typedef enum logic [1:0] {
        ST_FORWARDING = 2'h0,
        ST_BLOCKING = 2'h1,
        ST_LEARNING = 2'h2,
        ST_LISTENING = 2'h3
    } stp_state_t;

    function automatic logic [15:0] byte_addr(logic [15:0] idx);
        return {idx[13:0], 2'h0};
    endfunction

    // Picks the two-bit field of a port; port code 3 names no port.
    function automatic logic [1:0] port_fld2(logic [5:0] v, logic [1:0] p);
        case (p)
            2'h0: return v[1:0];
            2'h1: return v[3:2];
            2'h2: return v[5:4];
            default: return 2'h0;
        endcase
    endfunction

    function automatic logic port_bit(logic [2:0] m, logic [1:0] p);
        return (p == 2'h3) ? 1'b0 : m[p];
    endfunction
endpackage

// File: core/bcast_throttle.sv
`timescale 1ns/1ns
module bcast_throttle
    import fwd_cfg_pkg::*;
#(
    parameter int LEN_W = 11
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Interval tick and configuration.
    input wire logic tick,
    input wire logic enable,
    input wire logic [BCL_LVL_W-1:0] level,
    // Broadcast packet received on this port.
    input wire logic bc_valid,
    input wire logic [LEN_W-1:0] bc_len,
    // Discard decision for that packet.
    output logic drop
);
    localparam int CNT_W = BCL_LVL_W + BCL_UNIT_SHIFT + 1;

    logic [CNT_W-1:0] used_q;
    logic [CNT_W:0] allow;
    logic [CNT_W:0] sum;

    // Allowance is the level in 64-byte units; the sum is one bit wider so it never wraps.
    assign allow = (CNT_W + 1)'({level, {BCL_UNIT_SHIFT{1'b0}}});
    assign sum = {1'b0, used_q} + (CNT_W + 1)'(bc_len);
    assign drop = enable && bc_valid && (sum > allow);

    // Accepted bytes add up until the next interval tick restarts the allowance.
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            used_q <= '0;
        end else if (tick) begin
            used_q <= '0;
        end else if (bc_valid && !drop) begin
            used_q <= sum[CNT_W-1:0];
        end
    end
endmodule

// File: core/event_irq.sv
`timescale 1ns/1ns
module event_irq #(
    parameter int W = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Event pulses from the block.
    input wire logic [W-1:0] ev,
    // Register writes.
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire logic [W-1:0] wdata,
    // Register contents and the interrupt level.
    output logic [W-1:0] status_q,
    output logic [W-1:0] mask_q,
    output logic irq
);
    // A new event outranks a write-one-to-clear in the same cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(clr_wr ? wdata : '0)) | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_q <= '0;
        end else if (mask_wr) begin
            mask_q <= wdata;
        end
    end

    assign irq = |(status_q & mask_q);
endmodule

// File: core/port_fwd_cfg.sv
// Notes on behaviour
// - Two-bit spanning tree state per port at 5:4, 3:2, 1:0; reset forwarding.
// - State codes: 00 forwarding, 01 blocking, 10 learning, 11 listening.
// - Priority 7..0 picks its egress queue from bit pairs 15:14 down to 1:0.
// - Queue map resets to 3,3,2,2,1,0,0,1 for priorities 7 down to 0.
// - Control bit 1 copies packets received on mirrored ports to the sniffer.
// - Control bit 0 copies packets sent on mirrored ports to the sniffer.
// - Mirrored port map in bits 4:2; any number of ports may be set.
// - Bit 8 lets filtered packets be mirrored, to the sniffer only.
// - Mirrored filtered packets still count as filtered and raise the drop event.
// - Ingress type 11b takes destination from the VLAN tag; reset 00b.
// - Bits 26, 17, 8 enable broadcast throttling on ports 2, 1, 0.
// - Eight-bit levels allow level times 64 bytes per 1.72 ms; reset 02h.
// - Learn only if enabled and port state is forwarding or learning.
`timescale 1ns/1ns
module port_fwd_cfg
    import fwd_cfg_pkg::*;
#(
    parameter int LEN_W = 11,
    parameter int INTERVAL = INTERVAL_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Received packet decision request.
    input wire logic pkt_valid,
    input wire logic [1:0] pkt_port,
    input wire logic [2:0] pkt_prio,
    input wire logic [2:0] pkt_dest,
    input wire logic [2:0] pkt_vlan_dest,
    input wire logic pkt_filtered,
    input wire logic pkt_bcast,
    input wire logic [LEN_W-1:0] pkt_len,
    input wire logic [2:0] learn_en,
    // Received packet decision answer.
    output logic fwd_valid,
    output logic [2:0] fwd_dest,
    output logic [1:0] fwd_queue,
    output logic fwd_learn,
    output logic fwd_mirror,
    output logic fwd_filt_inc,
    output logic fwd_thr_drop,
    // Transmitted packet mirroring.
    input wire logic tx_valid,
    input wire logic [1:0] tx_port,
    output logic tx_mir_valid,
    output logic [2:0] tx_mir_dest,
    // Interrupt.
    output logic irq
);
    import fwd_cfg_pkg::*;

    localparam int IVL_W = $clog2(INTERVAL);
    localparam logic [IVL_W-1:0] IVL_LAST = IVL_W'(INTERVAL - 1);

    logic [W_STP-1:0] stp_q;
    logic [W_PQM-1:0] pqm_q;
    logic [W_MIR-1:0] mir_q;
    logic [W_ITS-1:0] its_q;
    logic [W_BCL-1:0] bcl_q;
    logic [31:0] rdata_q;
    logic [IVL_W-1:0] ivl_q;
    logic tick;
    logic [2:0] thr_drop;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;

    logic wr_stp;
    logic wr_pqm;
    logic wr_mir;
    logic wr_its;
    logic wr_bcl;
    logic wr_stat;
    logic wr_mask;

    logic fwd_valid_q;
    logic [2:0] fwd_dest_q;
    logic [1:0] fwd_queue_q;
    logic fwd_learn_q;
    logic fwd_mirror_q;
    logic fwd_filt_inc_q;
    logic fwd_thr_drop_q;
    logic tx_mir_valid_q;
    logic [2:0] tx_mir_dest_q;

    stp_state_t st;
    logic fwd_ok;
    logic vlan_mode;
    logic [2:0] base_dest;
    logic [2:0] snif;
    logic mir_rx_hit;
    logic thr;
    logic pass;
    logic mirror;
    logic [2:0] dest_d;
    logic learn_d;
    logic [1:0] queue_d;

    // Address decode of the write strobe.
    assign wr_stp = reg_wr && (reg_addr == byte_addr(IDX_STP));
    assign wr_pqm = reg_wr && (reg_addr == byte_addr(IDX_PQM));
    assign wr_mir = reg_wr && (reg_addr == byte_addr(IDX_MIR));
    assign wr_its = reg_wr && (reg_addr == byte_addr(IDX_ITS));
    assign wr_bcl = reg_wr && (reg_addr == byte_addr(IDX_BCL));
    assign wr_stat = reg_wr && (reg_addr == byte_addr(IDX_IRQ_STAT));
    assign wr_mask = reg_wr && (reg_addr == byte_addr(IDX_IRQ_MASK));

    // Spanning tree states; all ports come up forwarding.
    always_ff @(posedge clk) begin
        if (srst) begin
            stp_q <= RST_STP;
        end else if (wr_stp) begin
            stp_q <= reg_wdata[W_STP-1:0];
        end
    end

    // Priority to queue map.
    always_ff @(posedge clk) begin
        if (srst) begin
            pqm_q <= RST_PQM;
        end else if (wr_pqm) begin
            pqm_q <= reg_wdata[W_PQM-1:0];
        end
    end

    // Mirroring control. A sniffer map with several bits is stored as written;
    // the copy then goes to every marked port.
    always_ff @(posedge clk) begin
        if (srst) begin
            mir_q <= RST_MIR;
        end else if (wr_mir) begin
            mir_q <= reg_wdata[W_MIR-1:0];
        end
    end

    // Ingress type selection.
    always_ff @(posedge clk) begin
        if (srst) begin
            its_q <= RST_ITS;
        end else if (wr_its) begin
            its_q <= reg_wdata[W_ITS-1:0];
        end
    end

    // Broadcast limit enables and levels.
    always_ff @(posedge clk) begin
        if (srst) begin
            bcl_q <= RST_BCL;
        end else if (wr_bcl) begin
            bcl_q <= reg_wdata[W_BCL-1:0];
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (srst || !reg_rd) begin
            rdata_q <= '0;
        end else if (reg_addr == byte_addr(IDX_STP)) begin
            rdata_q <= 32'(stp_q);
        end else if (reg_addr == byte_addr(IDX_PQM)) begin
            rdata_q <= 32'(pqm_q);
        end else if (reg_addr == byte_addr(IDX_MIR)) begin
            rdata_q <= 32'(mir_q);
        end else if (reg_addr == byte_addr(IDX_ITS)) begin
            rdata_q <= 32'(its_q);
        end else if (reg_addr == byte_addr(IDX_BCL)) begin
            rdata_q <= 32'(bcl_q);
        end else if (reg_addr == byte_addr(IDX_IRQ_STAT)) begin
            rdata_q <= 32'(irq_stat);
        end else if (reg_addr == byte_addr(IDX_IRQ_MASK)) begin
            rdata_q <= 32'(irq_mask);
        end else begin
            rdata_q <= '0;
        end
    end
    assign reg_rdata = rdata_q;

    // Free-running interval counter shared by all three throttles.
    always_ff @(posedge clk) begin
        if (srst || tick) begin
            ivl_q <= '0;
        end else begin
            ivl_q <= ivl_q + 1'b1;
        end
    end
    assign tick = (ivl_q == IVL_LAST);

    // One throttle per port; each sees only broadcasts received on its own port.
    for (genvar p = 0; p < 3; p++) begin : g_thr
        bcast_throttle #(.LEN_W(LEN_W)) u_thr (
            .clk(clk),
            .srst(srst),
            .tick(tick),
            .enable(bcl_q[p*BCL_STRIDE+BCL_EN_OFS]),
            .level(bcl_q[p*BCL_STRIDE+:BCL_LVL_W]),
            .bc_valid(pkt_valid && pkt_bcast && (pkt_port == 2'(p))),
            .bc_len(pkt_len),
            .drop(thr_drop[p])
        );
    end

    // Decision for the packet on the request port, all from current settings.
    assign st = stp_state_t'(port_fld2(stp_q, pkt_port));
    assign fwd_ok = (st == ST_FORWARDING);
    assign vlan_mode = (port_fld2(its_q, pkt_port) == ITS_VLAN_DEST);
    assign base_dest = vlan_mode ? pkt_vlan_dest : pkt_dest;
    assign snif = mir_q[MIR_SNIF_LSB+:3];
    assign mir_rx_hit = mir_q[MIR_RX_BIT]
                        && port_bit(mir_q[MIR_MAP_LSB+:3], pkt_port);
    assign thr = port_bit(thr_drop, pkt_port);
    assign pass = fwd_ok && !pkt_filtered && !thr;
    // A filtered packet goes to the sniffer alone, and only when bit 8 allows it.
    assign mirror = mir_rx_hit
                    && (pass || (pkt_filtered && mir_q[MIR_FILT_BIT]));
    assign dest_d = (pass ? base_dest : 3'h0) | (mirror ? snif : 3'h0);
    assign learn_d = port_bit(learn_en, pkt_port)
                     && (st == ST_FORWARDING || st == ST_LEARNING);
    assign queue_d = pqm_q[{pkt_prio, 1'b0}+:2];

    // Decision answer, one cycle after the request.
    always_ff @(posedge clk) begin
        if (srst) begin
            fwd_valid_q <= 1'b0;
            fwd_dest_q <= 3'h0;
            fwd_queue_q <= 2'h0;
            fwd_learn_q <= 1'b0;
            fwd_mirror_q <= 1'b0;
        end else begin
            fwd_valid_q <= pkt_valid;
            fwd_dest_q <= pkt_valid ? dest_d : 3'h0;
            fwd_queue_q <= pkt_valid ? queue_d : 2'h0;
            fwd_learn_q <= pkt_valid && learn_d;
            fwd_mirror_q <= pkt_valid && mirror;
        end
    end

    // Counter and drop indications; a mirrored filtered packet still counts.
    always_ff @(posedge clk) begin
        if (srst) begin
            fwd_filt_inc_q <= 1'b0;
            fwd_thr_drop_q <= 1'b0;
        end else begin
            fwd_filt_inc_q <= pkt_valid && pkt_filtered;
            fwd_thr_drop_q <= pkt_valid && thr;
        end
    end

    // Transmit side copies to the sniffer for mirrored ports.
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_mir_valid_q <= 1'b0;
            tx_mir_dest_q <= 3'h0;
        end else begin
            tx_mir_valid_q <= tx_valid && mir_q[MIR_TX_BIT]
                              && port_bit(mir_q[MIR_MAP_LSB+:3], tx_port);
            tx_mir_dest_q <= snif;
        end
    end

    assign fwd_valid = fwd_valid_q;
    assign fwd_dest = fwd_dest_q;
    assign fwd_queue = fwd_queue_q;
    assign fwd_learn = fwd_learn_q;
    assign fwd_mirror = fwd_mirror_q;
    assign fwd_filt_inc = fwd_filt_inc_q;
    assign fwd_thr_drop = fwd_thr_drop_q;
    assign tx_mir_valid = tx_mir_valid_q;
    assign tx_mir_dest = tx_mir_valid_q ? tx_mir_dest_q : 3'h0;

    // Events feeding the interrupt; the drop event fires even when mirrored.
    assign ev[EV_FILT] = pkt_valid && pkt_filtered;
    assign ev[EV_THR] = pkt_valid && thr;
    assign ev[EV_STP] = pkt_valid && !fwd_ok;

    event_irq #(.W(EV_W)) u_irq (
        .clk(clk),
        .srst(srst),
        .ev(ev),
        .clr_wr(wr_stat),
        .mask_wr(wr_mask),
        .wdata(reg_wdata[EV_W-1:0]),
        .status_q(irq_stat),
        .mask_q(irq_mask),
        .irq(irq)
    );

    // Checks on the decision path.
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_reset_values: assert property ($past(srst) |->
        stp_q == RST_STP && pqm_q == RST_PQM && bcl_q == RST_BCL)
        else $error("Configuration not at reset values.");

    a_block_nofwd: assert property (
        pkt_valid && st != ST_FORWARDING && !mir_rx_hit |=> fwd_dest_q == 3'h0)
        else $error("Non-forwarding port forwarded a packet.");

    a_learn_gate: assert property (
        pkt_valid && (st == ST_BLOCKING || st == ST_LISTENING) |=> !fwd_learn_q)
        else $error("Learning in a state that forbids it.");

    a_queue_map: assert property (
        pkt_valid && !wr_pqm |=> fwd_queue_q == pqm_q[$past(pkt_prio)*2+:2])
        else $error("Egress queue does not follow the map.");

    a_rx_mirror: assert property (
        pkt_valid && mir_rx_hit && pass && !wr_mir |=> (fwd_dest_q & snif) == snif)
        else $error("Received packet not copied to the sniffer.");

    a_filt_nomirror: assert property (
        pkt_valid && pkt_filtered && !mir_q[MIR_FILT_BIT] |=> fwd_dest_q == 3'h0)
        else $error("Filtered packet was mirrored while disabled.");

    a_filt_count: assert property (
        pkt_valid && pkt_filtered |=> fwd_filt_inc_q && irq_stat[EV_FILT])
        else $error("Filtered packet not counted or not flagged.");

    a_tx_mirror: assert property (
        tx_valid && mir_q[MIR_TX_BIT] && port_bit(mir_q[MIR_MAP_LSB+:3], tx_port)
        && !wr_mir |=> tx_mir_valid_q && tx_mir_dest == snif)
        else $error("Transmitted packet not copied to the sniffer.");

    a_vlan_dest: assert property (
        pkt_valid && vlan_mode && pass && !mirror |=> fwd_dest_q == $past(pkt_vlan_dest))
        else $error("VLAN tag destination not used.");

    a_thr_off: assert property (
        pkt_valid && !port_bit({bcl_q[26], bcl_q[17], bcl_q[8]}, pkt_port)
        |=> !fwd_thr_drop_q)
        else $error("Broadcast dropped on an unthrottled port.");

    c_filt_mirror: cover property (pkt_valid && pkt_filtered && mirror);
    c_thr_drop: cover property (pkt_valid && thr ##1 fwd_thr_drop_q);
    c_tx_mirror: cover property (tx_valid ##1 tx_mir_valid_q);
    c_irq: cover property (ev != '0 ##1 irq);
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import fwd_cfg_pkg::*;
    // Short interval keeps the allowance restart inside a quick run.
    localparam int IV = 4000;
    int err_count = 0;
    int n_tests = 0;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic pkt_valid = 1'b0;
    logic [1:0] pkt_port = 2'h0;
    logic [2:0] pkt_prio = 3'h0;
    logic [2:0] pkt_dest = 3'h0;
    logic [2:0] pkt_vlan_dest = 3'h2;
    logic pkt_filtered = 1'b0;
    logic pkt_bcast = 1'b0;
    logic [10:0] pkt_len = 11'h000;
    logic [2:0] learn_en = 3'h7;
    logic tx_valid = 1'b0;
    logic [1:0] tx_port = 2'h0;
    logic fwd_valid, fwd_learn, fwd_mirror, fwd_filt_inc, fwd_thr_drop, tx_mir_valid, irq;
    logic [2:0] fwd_dest, tx_mir_dest;
    logic [1:0] fwd_queue;

    port_fwd_cfg #(.LEN_W(11), .INTERVAL(IV)) dut (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_prio(pkt_prio),
        .pkt_dest(pkt_dest), .pkt_vlan_dest(pkt_vlan_dest), .pkt_filtered(pkt_filtered),
        .pkt_bcast(pkt_bcast), .pkt_len(pkt_len), .learn_en(learn_en),
        .fwd_valid(fwd_valid), .fwd_dest(fwd_dest), .fwd_queue(fwd_queue),
        .fwd_learn(fwd_learn), .fwd_mirror(fwd_mirror), .fwd_filt_inc(fwd_filt_inc),
        .fwd_thr_drop(fwd_thr_drop), .tx_valid(tx_valid), .tx_port(tx_port),
        .tx_mir_valid(tx_mir_valid), .tx_mir_dest(tx_mir_dest), .irq(irq));

    // The clock toggles every 4 ns, half of its 8 ns period.
    initial begin
        forever #4 clk = ~clk;
    end

    // Bus addresses are computed locally so the bench does not lean on design helpers.
    function automatic logic [15:0] ba(input logic [15:0] idx);
        return {idx[13:0], 2'h0};
    endfunction

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] ex, input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, ex, reg_rdata)
    endtask

    // One packet request; the answer stands for one cycle after the next edge.
    task automatic send(input logic [1:0] pt, input logic [2:0] pr, input logic [2:0] ds,
                        input logic flt, input logic bc, input logic [10:0] ln);
        @(posedge clk);
        pkt_valid <= 1'b1;
        pkt_port <= pt;
        pkt_prio <= pr;
        pkt_dest <= ds;
        pkt_filtered <= flt;
        pkt_bcast <= bc;
        pkt_len <= ln;
        @(posedge clk);
        pkt_valid <= 1'b0;
        #1;
        `CHK("fwd_valid", 1'b1, fwd_valid)
    endtask

    task automatic send_tx(input logic [1:0] pt);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_port <= pt;
        @(posedge clk);
        tx_valid <= 1'b0;
        #1;
    endtask

    task automatic t_reset;
        rd_chk(ba(IDX_STP), 32'h0000_0000, "stp rst");
        rd_chk(ba(IDX_PQM), 32'h0000_FA41, "pqm rst");
        rd_chk(ba(IDX_MIR), 32'h0000_0000, "mir rst");
        rd_chk(ba(IDX_ITS), 32'h0000_0000, "its rst");
        rd_chk(ba(IDX_BCL), 32'h0008_0402, "bcl rst");
        rd_chk(16'h6110, 32'h0000_0000, "unmapped");
        wr(ba(IDX_STP), 32'hFFFF_FFFF);
        rd_chk(ba(IDX_STP), 32'h0000_003F, "stp ro");
        wr(ba(IDX_STP), 32'h0000_0000);
    endtask

    // Every state code on port 1, then the field positions of ports 0 and 2.
    task automatic t_stp;
        for (int s = 0; s < 4; s++) begin
            wr(ba(IDX_STP), 32'(s) << 2);
            send(2'h1, 3'h0, 3'h5, 1'b0, 1'b0, 11'h040);
            `CHK("stp dest", (s == 0) ? 3'h5 : 3'h0, fwd_dest)
            `CHK("stp learn", (s == 0 || s == 2) ? 1'b1 : 1'b0, fwd_learn)
        end
        send(2'h0, 3'h0, 3'h5, 1'b0, 1'b0, 11'h040);
        `CHK("port0 dest", 3'h5, fwd_dest)
        wr(ba(IDX_STP), 32'h0000_0010);
        send(2'h2, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("port2 dest", 3'h0, fwd_dest)
        wr(ba(IDX_STP), 32'h0000_0000);
        learn_en <= 3'h5;
        send(2'h1, 3'h0, 3'h5, 1'b0, 1'b0, 11'h040);
        `CHK("learn off", 1'b0, fwd_learn)
        learn_en <= 3'h7;
    endtask

    task automatic q_sweep(input logic [15:0] m);
        for (int p = 0; p < 8; p++) begin
            send(2'h0, p[2:0], 3'h2, 1'b0, 1'b0, 11'h040);
            `CHK("queue", m[2*p+:2], fwd_queue)
        end
    endtask

    task automatic t_queue;
        q_sweep(16'hFA41);
        wr(ba(IDX_PQM), 32'hFFFF_1B4E);
        rd_chk(ba(IDX_PQM), 32'h0000_1B4E, "pqm rw");
        q_sweep(16'h1B4E);
    endtask

    // Sniffer is port 2, mirrored port 1, both directions on.
    task automatic t_mirror;
        wr(ba(IDX_MIR), 32'h0000_008B);
        send(2'h1, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("rx mir dest", 3'h5, fwd_dest)
        `CHK("rx mir flag", 1'b1, fwd_mirror)
        send(2'h0, 3'h0, 3'h2, 1'b0, 1'b0, 11'h040);
        `CHK("unmirrored", 3'h2, fwd_dest)
        send(2'h1, 3'h0, 3'h1, 1'b1, 1'b0, 11'h040);
        `CHK("filt no mir", 3'h0, fwd_dest)
        `CHK("filt inc", 1'b1, fwd_filt_inc)
        wr(ba(IDX_MIR), 32'h0000_018F);
        send(2'h1, 3'h0, 3'h1, 1'b1, 1'b0, 11'h040);
        `CHK("filt mir dest", 3'h4, fwd_dest)
        `CHK("filt mir inc", 1'b1, fwd_filt_inc)
        send_tx(2'h1);
        `CHK("tx mir", 4'hC, {tx_mir_valid, tx_mir_dest})
        send_tx(2'h0);
        `CHK("tx mir p0", 4'hC, {tx_mir_valid, tx_mir_dest})
        send_tx(2'h2);
        `CHK("tx no mir", 1'b0, tx_mir_valid)
        wr(ba(IDX_MIR), 32'h0000_008D);
        send(2'h1, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("rx off", 4'h1, {fwd_mirror, fwd_dest})
        wr(ba(IDX_MIR), 32'h0000_0088);
        send_tx(2'h1);
        `CHK("tx off", 1'b0, tx_mir_valid)
        wr(ba(IDX_MIR), 32'h0000_0000);
    endtask

    task automatic t_vlan;
        wr(ba(IDX_ITS), 32'h0000_0030);
        send(2'h2, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("vlan dest", 3'h2, fwd_dest)
        send(2'h1, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("vlan other", 3'h1, fwd_dest)
        wr(ba(IDX_ITS), 32'h0000_0020);
        send(2'h2, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("vlan off", 3'h1, fwd_dest)
        wr(ba(IDX_ITS), 32'h0000_0000);
    endtask

    // Level 2 allows 128 bytes: two 64-byte broadcasts pass, the third is dropped.
    task automatic t_throttle;
        wr(ba(IDX_BCL), 32'h000A_0402);
        for (int i = 0; i < 3; i++) begin
            send(2'h1, 3'h0, 3'h1, 1'b0, 1'b1, 11'h040);
            `CHK("thr drop", (i == 2) ? 1'b1 : 1'b0, fwd_thr_drop)
            `CHK("thr dest", (i == 2) ? 3'h0 : 3'h1, fwd_dest)
        end
        send(2'h0, 3'h0, 3'h2, 1'b0, 1'b1, 11'h3FF);
        `CHK("thr off port", 1'b0, fwd_thr_drop)
        repeat (IV + 2) @(posedge clk);
        send(2'h1, 3'h0, 3'h1, 1'b0, 1'b1, 11'h040);
        `CHK("thr restart", 1'b0, fwd_thr_drop)
        wr(ba(IDX_BCL), 32'h0008_0402);
    endtask

    task automatic t_irq;
        wr(16'h6140, 32'h0000_0007);
        rd_chk(16'h6140, 32'h0000_0000, "stat clr");
        wr(16'h6144, 32'h0000_0001);
        rd_chk(16'h6144, 32'h0000_0001, "mask rw");
        wr(ba(IDX_MIR), 32'h0000_018B);
        send(2'h1, 3'h0, 3'h1, 1'b1, 1'b0, 11'h040);
        `CHK("irq filt", 1'b1, irq)
        wr(16'h6140, 32'h0000_0001);
        #1;
        `CHK("irq clr", 1'b0, irq)
        wr(ba(IDX_STP), 32'h0000_0004);
        send(2'h1, 3'h0, 3'h1, 1'b0, 1'b0, 11'h040);
        `CHK("irq masked", 1'b0, irq)
        rd_chk(16'h6140, 32'h0000_0004, "stat stp");
        wr(16'h6144, 32'h0000_0004);
        #1;
        `CHK("irq unmask", 1'b1, irq)
        wr(16'h6140, 32'h0000_0004);
        #1;
        `CHK("irq w1c", 1'b0, irq)
        wr(ba(IDX_STP), 32'h0000_0000);
        wr(ba(IDX_MIR), 32'h0000_0000);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang anywhere is cut short well inside the cycle budget.
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        close_out();
    end

    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_stp();
        t_queue();
        t_mirror();
        t_vlan();
        t_throttle();
        t_irq();
        close_out();
    end
endmodule
